//--- core/bru_core.sv
// Functional notes
// - left through carry to memory, carry gets bit7
// - left through carry into accumulator, memory kept
// - right rotate to memory, bit0 to bit7
// - right rotate into accumulator, memory and carry kept
// - right through carry to memory, carry gets bit0
// - right through carry into accumulator, carry gets bit0
// - left rotate to memory, bit7 to bit0
module bru_core
    import bru_pkg::*;
(
    input  wire logic     CLK_SYS_I,
    input  wire logic     RST_I,
    input  wire bru_req_t REQ_I,
    output bru_rsp_t      RSP_O
);

    bru_state_t st_reg;
    bru_state_t st_next;

    // one position left, fill enters bit 0
    function automatic logic [7:0] shift_in_left(input logic [7:0] d, input logic fill);
        return {d[BRU_MSB-1:BRU_LSB], fill};
    endfunction

    // one position right, fill enters bit 7
    function automatic logic [7:0] shift_in_right(input logic [7:0] d, input logic fill);
        return {fill, d[BRU_MSB:BRU_LSB+1]};
    endfunction

    // set when the op writes the accumulator rather than memory
    function automatic logic targets_acc(input bru_op_t op);
        return op[BRU_OP_ACC_BIT];
    endfunction

    // carry out in bit 8, rotated byte below it
    function automatic logic [8:0] rotate(input bru_op_t op, input logic [7:0] d, input logic c);
        logic [8:0] r;
        r = {c, d};
        case (op)
            BRU_OP_ROTATE_LEFT_MEM, BRU_OP_ROTATE_LEFT_TO_ACC: begin
                r = {c, shift_in_left(d, d[BRU_MSB])};
            end
            BRU_OP_ROTATE_LEFT_THRU_CARRY_MEM, BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC: begin
                r = {d[BRU_MSB], shift_in_left(d, c)};
            end
            BRU_OP_ROTATE_RIGHT_MEM, BRU_OP_ROTATE_RIGHT_TO_ACC: begin
                r = {c, shift_in_right(d, d[BRU_LSB])};
            end
            default: begin
                r = {d[BRU_LSB], shift_in_right(d, c)};
            end
        endcase
        return r;
    endfunction

    always_comb begin
        logic [8:0] rot;
        rot     = rotate(REQ_I.op, REQ_I.operand, REQ_I.carry);
        // result, carry and flags stand until the next taken request
        st_next = st_reg;
        st_next.rsp.done   = REQ_I.valid;
        st_next.rsp.mem_we = 1'b0;
        st_next.rsp.acc_we = 1'b0;
        if (REQ_I.valid) begin
            st_next.rsp.mem_we = ~targets_acc(REQ_I.op);
            st_next.rsp.acc_we = targets_acc(REQ_I.op);
            st_next.rsp.result = rot[BRU_MSB:BRU_LSB];
            // plain ops hand the old carry back, flags pass through
            st_next.rsp.carry  = rot[BRU_CARRY_POS];
            st_next.rsp.flags  = REQ_I.flags;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            st_reg.rsp.mem_we <= 1'b0;
            st_reg.rsp.acc_we <= 1'b0;
            st_reg.rsp.result <= BRU_DATA_RST;
            st_reg.rsp.carry  <= BRU_CARRY_RST;
            st_reg.rsp.flags  <= BRU_FLAGS_RST;
            st_reg.rsp.done   <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign RSP_O = st_reg.rsp;

    a_left_carry_mem: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && REQ_I.valid && REQ_I.op == BRU_OP_ROTATE_LEFT_THRU_CARRY_MEM
        |=> RSP_O.mem_we
        && !RSP_O.acc_we
        && RSP_O.result == {$past(REQ_I.operand[BRU_MSB-1:BRU_LSB]), $past(REQ_I.carry)}
        && RSP_O.carry == $past(REQ_I.operand[BRU_MSB]))
        else $error("left through carry to memory wrong");

    a_left_carry_acc: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && REQ_I.valid && REQ_I.op == BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC
        |=> RSP_O.acc_we
        && !RSP_O.mem_we
        && RSP_O.result == {$past(REQ_I.operand[BRU_MSB-1:BRU_LSB]), $past(REQ_I.carry)}
        && RSP_O.carry == $past(REQ_I.operand[BRU_MSB]))
        else $error("left through carry to accumulator wrong");

    a_right_mem_result: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && REQ_I.valid && REQ_I.op == BRU_OP_ROTATE_RIGHT_MEM
        |=> RSP_O.mem_we
        && !RSP_O.acc_we
        && RSP_O.result == {$past(REQ_I.operand[BRU_LSB]), $past(REQ_I.operand[BRU_MSB:BRU_LSB+1])}
        && RSP_O.carry == $past(REQ_I.carry))
        else $error("right rotate to memory wrong");

    a_right_acc_result: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && REQ_I.valid && REQ_I.op == BRU_OP_ROTATE_RIGHT_TO_ACC
        |=> RSP_O.acc_we
        && !RSP_O.mem_we
        && RSP_O.result == {$past(REQ_I.operand[BRU_LSB]), $past(REQ_I.operand[BRU_MSB:BRU_LSB+1])}
        && RSP_O.carry == $past(REQ_I.carry))
        else $error("right rotate to accumulator wrong");

    a_right_carry_mem: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && REQ_I.valid && REQ_I.op == BRU_OP_ROTATE_RIGHT_THRU_CARRY_MEM
        |=> RSP_O.mem_we
        && !RSP_O.acc_we
        && RSP_O.result == {$past(REQ_I.carry), $past(REQ_I.operand[BRU_MSB:BRU_LSB+1])}
        && RSP_O.carry == $past(REQ_I.operand[BRU_LSB]))
        else $error("right through carry to memory wrong");

    a_right_carry_acc: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && REQ_I.valid && REQ_I.op == BRU_OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC
        |=> RSP_O.acc_we
        && !RSP_O.mem_we
        && RSP_O.result == {$past(REQ_I.carry), $past(REQ_I.operand[BRU_MSB:BRU_LSB+1])}
        && RSP_O.carry == $past(REQ_I.operand[BRU_LSB]))
        else $error("right through carry to accumulator wrong");

    a_left_mem_result: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && REQ_I.valid && REQ_I.op == BRU_OP_ROTATE_LEFT_MEM
        |=> RSP_O.mem_we
        && !RSP_O.acc_we
        && RSP_O.result == {$past(REQ_I.operand[BRU_MSB-1:BRU_LSB]), $past(REQ_I.operand[BRU_MSB])}
        && RSP_O.carry == $past(REQ_I.carry))
        else $error("left rotate to memory wrong");

    // left rotate into accumulator, carry kept
    a_left_acc_result: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && REQ_I.valid && REQ_I.op == BRU_OP_ROTATE_LEFT_TO_ACC
        |=> RSP_O.acc_we
        && !RSP_O.mem_we
        && RSP_O.result == {$past(REQ_I.operand[BRU_MSB-1:BRU_LSB]), $past(REQ_I.operand[BRU_MSB])}
        && RSP_O.carry == $past(REQ_I.carry))
        else $error("left rotate to accumulator wrong");

    a_flags_kept: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && REQ_I.valid
        |=> RSP_O.done
        && RSP_O.flags == $past(REQ_I.flags))
        else $error("status flags changed by rotate");

    a_plain_carry_kept: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && REQ_I.valid && !REQ_I.op[BRU_OP_CARRY_BIT]
        |=> RSP_O.carry == $past(REQ_I.carry))
        else $error("plain rotate changed carry");

    // no strobe without a taken request
    a_idle_no_write: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && !REQ_I.valid
        |=> !RSP_O.mem_we
        && !RSP_O.acc_we
        && !RSP_O.done)
        else $error("write strobe without request");

    // result stands while idle
    a_idle_result_held: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && !REQ_I.valid
        |=> $stable(RSP_O.result))
        else $error("result moved without request");

    a_idle_carry_held: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && !REQ_I.valid
        |=> $stable(RSP_O.carry))
        else $error("carry moved without request");

    a_idle_flags_held: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !RST_I && !REQ_I.valid
        |=> $stable(RSP_O.flags))
        else $error("flags moved without request");

    a_acc_keeps_mem: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        RSP_O.acc_we
        |-> !RSP_O.mem_we && RSP_O.done)
        else $error("accumulator write also strobed memory");

    a_mem_keeps_acc: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        RSP_O.mem_we
        |-> !RSP_O.acc_we && RSP_O.done)
        else $error("memory write also strobed accumulator");

    // an answer only follows a request taken out of reset
    a_done_needs_request: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        RSP_O.done
        |-> $past(REQ_I.valid) && !$past(RST_I))
        else $error("answer without taken request");

    // reset clears every output field
    a_reset_clears_outputs: assert property (@(posedge CLK_SYS_I)
        RST_I
        |=> RSP_O == '0)
        else $error("outputs not cleared by reset");

endmodule

//--- inc/bru_pkg.sv
package bru_pkg;

    localparam int unsigned BRU_DATA_W = 8;
    localparam int unsigned BRU_MSB    = 7;
    localparam int unsigned BRU_LSB    = 0;

    // bit positions inside the op code and the 9-bit rotate word
    localparam int unsigned BRU_OP_ACC_BIT   = 0;
    localparam int unsigned BRU_OP_CARRY_BIT = 1;
    localparam int unsigned BRU_CARRY_POS    = 8;

    localparam logic [7:0] BRU_DATA_RST  = 8'h00;
    localparam logic       BRU_CARRY_RST = 1'b0;
    localparam logic [2:0] BRU_FLAGS_RST = 3'h0;

    // operation select from the decoder
    typedef enum logic [2:0] {
        BRU_OP_ROTATE_LEFT_MEM                = 3'b000,
        BRU_OP_ROTATE_LEFT_TO_ACC             = 3'b001,
        BRU_OP_ROTATE_LEFT_THRU_CARRY_MEM     = 3'b010,
        BRU_OP_ROTATE_LEFT_THRU_CARRY_TO_ACC  = 3'b011,
        BRU_OP_ROTATE_RIGHT_MEM               = 3'b100,
        BRU_OP_ROTATE_RIGHT_TO_ACC            = 3'b101,
        BRU_OP_ROTATE_RIGHT_THRU_CARRY_MEM    = 3'b110,
        BRU_OP_ROTATE_RIGHT_THRU_CARRY_TO_ACC = 3'b111
    } bru_op_t;

    // request from the instruction decoder
    typedef struct packed {
        logic       valid;
        bru_op_t    op;
        logic [7:0] operand;
        logic       carry;
        logic [2:0] flags;
    } bru_req_t;

    // answer to memory, accumulator and status register
    typedef struct packed {
        logic       mem_we;
        logic       acc_we;
        logic [7:0] result;
        logic       carry;
        logic [2:0] flags;
        logic       done;
    } bru_rsp_t;

    typedef struct packed {
        bru_rsp_t rsp;
    } bru_state_t;

endpackage

//--- verification/bru_status_model.sv
module bru_status_model
    import bru_pkg::*;
(
    input  wire logic     clk_i,
    input  wire bru_rsp_t rsp_i,
    output logic [7:0]    mem_o,
    output logic [7:0]    acc_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // memory and accumulator take the result only on their own strobe
    always_ff @(posedge clk_i) begin
        if (rsp_i.mem_we) mem_o <= rsp_i.result;
        if (rsp_i.acc_we) acc_o <= rsp_i.result;
    end
endmodule

//--- verification/byte_rotate_unit_test.sv
module byte_rotate_unit_test;
    import bru_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [2:0] op;
        logic [7:0] d;
        logic       c;
        logic [7:0] r;
        logic       co;
    } bru_row_t;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    bru_req_t   req = '0;
    bru_rsp_t   rsp;
    logic [7:0] mem;
    logic [7:0] acc;
    int         mismatches = 0;
    int         n_compared = 0;
    bru_row_t   rows [8] = '{'{3'h0, 8'h4a, 1'b1, 8'h94, 1'b1}, '{3'h1, 8'hb5, 1'b0, 8'h6b, 1'b0},
                             '{3'h2, 8'hb5, 1'b0, 8'h6a, 1'b1}, '{3'h3, 8'h4a, 1'b1, 8'h95, 1'b0},
                             '{3'h4, 8'h4a, 1'b1, 8'h25, 1'b1}, '{3'h5, 8'hb5, 1'b0, 8'hda, 1'b0},
                             '{3'h6, 8'hb5, 1'b0, 8'h5a, 1'b1}, '{3'h7, 8'h4a, 1'b1, 8'ha5, 1'b0}};
    always #4 clk = ~clk;
    bru_core i_bru_core (.CLK_SYS_I(clk), .RST_I(rst), .REQ_I(req), .RSP_O(rsp));
    bru_status_model i_bru_status_model (.clk_i(clk), .rsp_i(rsp), .mem_o(mem), .acc_o(acc));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({1'b0, rsp}, 16'h0000);
        for (int i = 0; i <= 8; i++) begin
            @(posedge clk);
            req <= (i < 8) ? {1'b1, rows[i].op, rows[i].d, rows[i].c, 3'h5} : '0;
            #1;
            if (i > 0) chk({1'b0, rsp}, {1'b0, ~rows[i-1].op[0], rows[i-1].op[0], rows[i-1].r, rows[i-1].co, 3'h5, 1'b1});
        end
        $display("rotate table done");
        @(posedge clk);
        #1;
        chk({1'b0, rsp}, {1'b0, 2'b00, 8'ha5, 1'b0, 3'h5, 1'b0});
        chk({acc, mem}, {8'ha5, 8'h5a});
        $display("idle hold done");
        @(posedge clk);
        req <= {1'b1, 3'h3, 8'h4a, 1'b1, 3'h7};
        rst <= 1'b1;
        @(posedge clk);
        req <= '0;
        #1;
        chk({1'b0, rsp}, 16'h0000);
        // hold reset one more edge, then release with the request line idle
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        req <= {1'b1, 3'h6, 8'h81, 1'b0, 3'h2};
        #1;
        chk({1'b0, rsp}, 16'h0000);
        @(posedge clk);
        req <= '0;
        #1;
        chk({1'b0, rsp}, {1'b0, 2'b10, 8'h40, 1'b1, 3'h2, 1'b1});
        @(posedge clk);
        #1;
        chk({acc, mem}, {8'ha5, 8'h40});
        $display("reset done");
        summarize();
    end
endmodule
